//--- shared/lis_pkg.sv
// Package for the indicator and interrupt-summary block.
// Assumes a 25 MHz aclk and an AXI4-Lite register slave with 32-bit data.
package lis_pkg;

    // Register indices and byte addresses (index times four).
    localparam logic [7:0] LIS_IDX_GLOBAL_STATUS = 8'h17;
    localparam logic [7:0] LIS_IDX_INDICATOR_CONTROL = 8'h18;
    localparam logic [7:0] LIS_IDX_IRQ_STATUS = 8'h19;
    localparam logic [7:0] LIS_IDX_IRQ_MASK = 8'h1A;
    localparam logic [9:0] LIS_ADDR_GLOBAL_STATUS = {LIS_IDX_GLOBAL_STATUS, 2'b00};
    localparam logic [9:0] LIS_ADDR_INDICATOR_CONTROL = {LIS_IDX_INDICATOR_CONTROL, 2'b00};
    localparam logic [9:0] LIS_ADDR_IRQ_STATUS = {LIS_IDX_IRQ_STATUS, 2'b00};
    localparam logic [9:0] LIS_ADDR_IRQ_MASK = {LIS_IDX_IRQ_MASK, 2'b00};

    // Indicator control field positions.
    localparam int LIS_CTL_DISABLE = 15;
    localparam int LIS_CTL_STRETCH_LO = 12;
    localparam int LIS_CTL_FORCE_IRQ = 11;
    localparam int LIS_CTL_BLINK_LO = 8;
    localparam int LIS_CTL_DUPLEX_MSB = 7;
    localparam int LIS_CTL_TX_LSB = 6;
    localparam int LIS_CTL_LINK_LO = 3;
    localparam int LIS_CTL_DUPLEX_LSB = 2;
    localparam int LIS_CTL_RX = 1;
    localparam int LIS_CTL_TX_MSB = 0;

    // Reset value of the indicator control register: stretch 4, blink 1.
    localparam logic [15:0] LIS_CTL_RESET = 16'h4100;

    // AXI responses.
    localparam logic [1:0] LIS_RESP_OKAY = 2'h0;
    localparam logic [1:0] LIS_RESP_SLVERR = 2'h2;

    // Event status bits.
    localparam int LIS_EV_PORT_IRQ = 0;
    localparam int LIS_EV_LINK_CHG = 1;
    localparam int LIS_EV_NUM = 2;

    // Time base: 21 ms tick unit at 25 MHz (longest-time rounding down).
    localparam int LIS_CLK_HZ = 25000000;
    localparam int LIS_TICK_MS = 21;
    localparam int LIS_TICK_CYCLES = LIS_CLK_HZ / 1000 * LIS_TICK_MS;

    // Line-state inputs from the transceiver core.
    typedef struct packed {
        logic tx_act;
        logic rx_act;
        logic link_up;
        logic full_duplex;
        logic collision;
        logic fiber_link_up;
        logic master;
        logic port_irq;
    } lis_line_s;

    // Indicator outputs, all active low.
    typedef struct packed {
        logic transmit_indicator_n;
        logic receive_indicator_n;
        logic link_indicator_n;
        logic duplex_indicator_n;
    } lis_ind_s;

endpackage : lis_pkg

//--- src/lis_stretch.sv
// Pulse stretcher for one activity source, counting 21 ms ticks.
// Assumes a one-cycle tick enable on the same clock.
`timescale 1ns/1ns
`default_nettype none
module lis_stretch
    import lis_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Control.
    input wire logic tick,
    input wire logic [2:0] code,
    // Activity in and stretched out.
    input wire logic act,
    output logic act_out
);

    logic [6:0] cnt_ff;

    // Load 2^(code-1) ticks on activity so the hold spans one tick less than that count up to the full count.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= 7'h00;
        end else if (act && code != 3'h0) begin
            cnt_ff <= 7'(7'h01 << (code - 3'h1));
        end else if (tick && cnt_ff != 7'h00) begin
            cnt_ff <= cnt_ff - 7'h01;
        end
    end

    // Code zero passes activity straight through.
    assign act_out = act || (code != 3'h0 && cnt_ff != 7'h00);

endmodule : lis_stretch
`default_nettype wire

//--- src/lis_top.sv
// Indicator and interrupt-summary logic with an AXI4-Lite register slave.
// Assumes line-state inputs arrive asynchronously from the transceiver core.
// Assumes the software reset comes as a level from the register set on the same clock.
// Function
// - Summary bit is one while the port interrupt is active, read-only, resets zero.
// - Summary stays set until port interrupt flags clear on status read.
// - Stretch field 14:12 sets activity hold, zero disables, reset four.
// - Force bit asserts the active-low interrupt output regardless of status.
// - Blink field 10:8 chooses period 42 to 672 ms, reset one.
// - Transmit mode bits 0 and 6 choose activity or blink behaviour.
// - Link field 5:3 selects direct, master/slave or combined link display.
// - Duplex codes 00 and 01 show duplex, 00 blinking on collision.
// - Receive bit chooses activity with link or activity only.
// - Indicators are active low: high is off, low is on.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module lis_top
    import lis_pkg::*;
(
    // Clock, hardware reset and software reset.
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic soft_reset,
    // AXI4-Lite write address and data.
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Line state from the core and indicator outputs.
    input wire lis_line_s line_in,
    output lis_ind_s indicators,
    // Interrupt outputs.
    output logic interrupt_out_n,
    output logic irq
);

    lis_line_s sync1_ff;
    lis_line_s line_ff;
    logic [15:0] ctl_ff;
    logic gstat_ff;
    logic [LIS_EV_NUM-1:0] ist_ff;
    logic [LIS_EV_NUM-1:0] imask_ff;
    logic link_d_ff;
    logic [$clog2(LIS_TICK_CYCLES)-1:0] div_ff;
    logic tick;
    logic [5:0] blink_cnt_ff;
    logic blink_ff;
    logic [9:0] awaddr_ff;
    logic aw_have_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic w_have_ff;
    logic wr_go;
    logic [9:0] rd_addr;
    logic rd_go;
    logic tx_str;
    logic rx_str;
    logic [2:0] stretch_code;
    logic [2:0] blink_code;
    logic [1:0] tx_mode;
    logic [1:0] dup_mode;
    logic [2:0] link_mode;
    logic any_act;
    logic tx_on;
    logic rx_on;
    logic link_on;
    logic dup_on;
    logic [5:0] blink_half;
    logic [LIS_EV_NUM-1:0] ev_raw;
    logic ist_clr;

    // Two-flop synchroniser for the asynchronous line state.
    // Each bit is a slow independent level, so a bit that settles one cycle after its
    // neighbours only delays that one indicator by a cycle; no word must cross intact.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_ff <= '0;
            line_ff <= '0;
        end else begin
            sync1_ff <= line_in;
            line_ff <= sync1_ff;
        end
    end

    // Field views of the control register.
    // Transmit and duplex modes are split codes whose two bits are not adjacent.
    assign stretch_code = ctl_ff[LIS_CTL_STRETCH_LO +: 3];
    assign blink_code = ctl_ff[LIS_CTL_BLINK_LO +: 3];
    assign tx_mode = {ctl_ff[LIS_CTL_TX_MSB], ctl_ff[LIS_CTL_TX_LSB]};
    assign dup_mode = {ctl_ff[LIS_CTL_DUPLEX_MSB], ctl_ff[LIS_CTL_DUPLEX_LSB]};
    assign link_mode = ctl_ff[LIS_CTL_LINK_LO +: 3];

    // Divider giving one 21 ms tick enable.
    // Every slower rate in the block counts these ticks, so all logic stays on aclk.
    // Holds and blink periods are whole numbers of ticks, so they sit at the short end.
    always_ff @(posedge aclk) begin
        if (!aresetn || div_ff == ($clog2(LIS_TICK_CYCLES))'(LIS_TICK_CYCLES - 1)) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end
    assign tick = (div_ff == ($clog2(LIS_TICK_CYCLES))'(LIS_TICK_CYCLES - 1));

    // Blink half-period in ticks: 42 ms period is one tick each half, doubling per code.
    // Reserved codes fall back to the fastest rate rather than freezing the lamp.
    assign blink_half = (blink_code > 3'h4) ? 6'h01 : 6'(6'h01 << blink_code);

    // Blink phase toggles every half period.
    // The compare uses >= so that a change to a shorter period never strands the count
    // above its new limit.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blink_cnt_ff <= 6'h00;
            blink_ff <= 1'b0;
        end else if (tick) begin
            if (blink_cnt_ff + 6'h01 >= blink_half) begin
                blink_cnt_ff <= 6'h00;
                blink_ff <= ~blink_ff;
            end else begin
                blink_cnt_ff <= blink_cnt_ff + 6'h01;
            end
        end
    end

    // Stretched transmit and receive activity.
    // Both sources share the stretch code; a new pulse restarts the hold at full length.
    lis_stretch u_tx_str (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .code(stretch_code),
        .act(line_ff.tx_act),
        .act_out(tx_str)
    );
    lis_stretch u_rx_str (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .code(stretch_code),
        .act(line_ff.rx_act),
        .act_out(rx_str)
    );
    assign any_act = tx_str || rx_str;

    // Indicator decode; logic high here means lit.
    // The blink phase is shared, so every blinking lamp blinks in step with the others.
    // Reserved duplex code 11 keeps the duplex lamp dark.
    always_comb begin
        case (tx_mode)
            2'b00: tx_on = tx_str;
            2'b01: tx_on = any_act;
            2'b10: tx_on = any_act ? blink_ff : line_ff.link_up;
            default: tx_on = any_act && blink_ff;
        endcase
        rx_on = ctl_ff[LIS_CTL_RX] ? (rx_str || line_ff.link_up) : rx_str;
        case (link_mode)
            3'b000: link_on = line_ff.link_up;
            3'b011: link_on = line_ff.link_up && line_ff.master;
            default: link_on = line_ff.link_up && (any_act ? blink_ff : 1'b1);
        endcase
        case (dup_mode)
            2'b00: dup_on = line_ff.collision ? blink_ff : line_ff.full_duplex;
            2'b01: dup_on = line_ff.full_duplex;
            2'b10: dup_on = line_ff.fiber_link_up;
            default: dup_on = 1'b0;
        endcase
    end

    // Registered active-low pins, forced off when disabled.
    // Registering the pins keeps decode glitches away from the lamp drivers.
    always_ff @(posedge aclk) begin
        if (!aresetn || ctl_ff[LIS_CTL_DISABLE]) begin
            indicators <= '1;
        end else begin
            indicators.transmit_indicator_n <= ~tx_on;
            indicators.receive_indicator_n <= ~rx_on;
            indicators.link_indicator_n <= ~link_on;
            indicators.duplex_indicator_n <= ~dup_on;
        end
    end

    // Port interrupt summary follows the core's flag until cleared by its status read.
    // Software reset clears the bit as well; the core's flag sets it again if still raised.
    // Writes to the global status register are answered but change nothing here.
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset) begin
            gstat_ff <= 1'b0;
        end else begin
            gstat_ff <= line_ff.port_irq;
        end
    end

    // Write channel capture; address and data taken in either order.
    // Each channel is held in its own slot; a held slot drops its ready until the pair is acted on,
    // which waits until the response of the previous write has been taken.
    assign s_axi_awready = !aw_have_ff;
    assign s_axi_wready = !w_have_ff;
    assign wr_go = aw_have_ff && w_have_ff && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            awaddr_ff <= 10'h000;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_have_ff) begin
                aw_have_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_have_ff <= 1'b0;
            end
            if (s_axi_wvalid && !w_have_ff) begin
                w_have_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end else if (wr_go) begin
                w_have_ff <= 1'b0;
            end
        end
    end

    // Write response.
    // Unmapped addresses answer with a slave error; the global status write is accepted
    // and ignored, since its only bit is read-only.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= LIS_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            if (awaddr_ff == LIS_ADDR_GLOBAL_STATUS || awaddr_ff == LIS_ADDR_INDICATOR_CONTROL
                    || awaddr_ff == LIS_ADDR_IRQ_STATUS || awaddr_ff == LIS_ADDR_IRQ_MASK) begin
                s_axi_bresp <= LIS_RESP_OKAY;
            end else begin
                s_axi_bresp <= LIS_RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Indicator control; only hardware reset restores defaults.
    // Byte lanes above bit 15 are ignored; a software reset leaves every field as it is.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_ff <= LIS_CTL_RESET;
        end else if (wr_go && awaddr_ff == LIS_ADDR_INDICATOR_CONTROL) begin
            if (wstrb_ff[0]) begin
                ctl_ff[7:0] <= wdata_ff[7:0];
            end
            if (wstrb_ff[1]) begin
                ctl_ff[15:8] <= wdata_ff[15:8];
            end
        end
    end

    // Interrupt mask register.
    // Only the low byte lane carries mask bits.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            imask_ff <= '0;
        end else if (wr_go && awaddr_ff == LIS_ADDR_IRQ_MASK && wstrb_ff[0]) begin
            imask_ff <= wdata_ff[LIS_EV_NUM-1:0];
        end
    end

    // Previous link level, for spotting a change of link state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_d_ff <= 1'b0;
        end else begin
            link_d_ff <= line_ff.link_up;
        end
    end

    // Raw events and the write-one-to-clear strobe of the status register.
    // The port event fires on the rise of the synchronised flag, the link event on a change.
    assign ev_raw[LIS_EV_PORT_IRQ] = line_ff.port_irq && !gstat_ff;
    assign ev_raw[LIS_EV_LINK_CHG] = line_ff.link_up != link_d_ff;
    assign ist_clr = wr_go && awaddr_ff == LIS_ADDR_IRQ_STATUS && wstrb_ff[0];

    // One sticky bit per event. An event in the clearing cycle wins, so software never
    // loses an event that lands while it acknowledges an older one.
    for (genvar gi = 0; gi < LIS_EV_NUM; gi++) begin : g_ist
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ist_ff[gi] <= 1'b0;
            end else if (ev_raw[gi]) begin
                ist_ff[gi] <= 1'b1;
            end else if (ist_clr && wdata_ff[gi]) begin
                ist_ff[gi] <= 1'b0;
            end
        end
    end

    // Interrupt outputs; force bit asserts the pin regardless of status.
    // The summary pin follows the port flag only; the event interrupt is separate and
    // never touches it.
    assign irq = |(ist_ff & imask_ff);
    assign interrupt_out_n = ~(gstat_ff || ctl_ff[LIS_CTL_FORCE_IRQ]);

    // Read channel: one read at a time, answered the cycle after the address.
    // The address is decoded straight from the bus in the cycle it is taken, and ready
    // stays low while an answer waits for the master.
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_go = s_axi_arvalid && !s_axi_rvalid;
    assign rd_addr = s_axi_araddr;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= LIS_RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= LIS_RESP_OKAY;
            if (rd_addr == LIS_ADDR_GLOBAL_STATUS) begin
                s_axi_rdata <= {31'h00000000, gstat_ff};
            end else if (rd_addr == LIS_ADDR_INDICATOR_CONTROL) begin
                s_axi_rdata <= {16'h0000, ctl_ff};
            end else if (rd_addr == LIS_ADDR_IRQ_STATUS) begin
                s_axi_rdata <= {30'h00000000, ist_ff};
            end else if (rd_addr == LIS_ADDR_IRQ_MASK) begin
                s_axi_rdata <= {30'h00000000, imask_ff};
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= LIS_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : lis_top
`default_nettype wire

//--- test/lis_monitor.sv
// Checker for the indicator and interrupt-summary block.
// Assumes it is bound to lis_top and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module lis_monitor
    import lis_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus.
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Line state and outputs.
    input wire lis_line_s line_in,
    input wire lis_ind_s indicators,
    input wire logic interrupt_out_n
);
    logic wr_ctl;
    logic force_ff;
    logic dis_ff;
    // Spots a control write whose address and data are taken at one edge.
    assign wr_ctl = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr == LIS_ADDR_INDICATOR_CONTROL && s_axi_wstrb[1];
    // Mirrors the force and disable bits as software last wrote them.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            force_ff <= 1'b0;
            dis_ff <= 1'b0;
        end else if (wr_ctl) begin
            force_ff <= s_axi_wdata[LIS_CTL_FORCE_IRQ];
            dis_ff <= s_axi_wdata[LIS_CTL_DISABLE];
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_dark: assert property (
        $rose(aresetn) |-> indicators == 4'hF && interrupt_out_n)
        else $error("outputs not idle after reset");
    a_summary_set: assert property (line_in.port_irq [*4] |-> !interrupt_out_n)
        else $error("interrupt not raised for port interrupt");
    a_summary_clear: assert property (
        (!line_in.port_irq && !force_ff) [*4] |-> interrupt_out_n)
        else $error("interrupt stays after port interrupt cleared");
    a_force_low: assert property (force_ff [*3] |-> !interrupt_out_n)
        else $error("forced interrupt not driven");
    a_disable_dark: assert property (dis_ff [*3] |-> indicators == 4'hF)
        else $error("indicator lit while disabled");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    c_forced: cover property (force_ff ##1 !interrupt_out_n);
    c_dark: cover property (dis_ff ##3 indicators == 4'hF);
    c_summary: cover property (line_in.port_irq ##4 !interrupt_out_n);
endmodule : lis_monitor
bind lis_top lis_monitor mon_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .line_in, .indicators,
    .interrupt_out_n);
`default_nettype wire

//--- test/lis_lamps.sv
// Model of the lamps and the host interrupt input on the far side.
// Assumes the indicator pins sink lamp current, so a low pin lights it.
`timescale 1ns/1ns
`default_nettype none
module lis_lamps
    import lis_pkg::*;
(
    // Pins from the block.
    input wire lis_ind_s indicators,
    input wire logic interrupt_out_n,
    // Lamp and host view.
    output logic [3:0] lit,
    output logic host_irq
);
    // A lamp glows while its pin is low; the host sees a low pin as a request.
    assign lit = ~indicators;
    assign host_irq = ~interrupt_out_n;
endmodule : lis_lamps
`default_nettype wire

//--- test/test_led_and_interrupt_status.sv
// Testbench for the indicator and interrupt-summary block.
// Assumes lis_top, the lamp model and the checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module test_led_and_interrupt_status
    import lis_pkg::*;
;
    logic aclk, aresetn, soft_reset, irq, host_irq, interrupt_out_n;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb, lit;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    lis_line_s line_in;
    lis_ind_s indicators;
    int err_total, samples_checked;
    lis_top dut_u (.aclk, .aresetn, .soft_reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_in, .indicators, .interrupt_out_n,
        .irq);
    lis_lamps lamp_u (.indicators, .interrupt_out_n, .lit, .host_irq);
    // Free-running 25 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    task automatic test_done;
        if (err_total == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Ends a bus transfer; a missing answer closes the run.
    task automatic fin(input logic ok);
        if (!ok) begin
            err_total++;
            $display("wrong value at %0t: bus answer missing", $time);
            test_done();
        end
        @(posedge aclk);
    endtask : fin
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 40);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        fin(s_axi_bvalid);
    endtask : wr
    task automatic rd(input logic [9:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 40);
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        fin(s_axi_rvalid);
    endtask : rd
    // Line inputs take three cycles to reach the pins.
    task automatic settle;
        repeat (5) @(posedge aclk);
    endtask : settle
    task automatic hw_reset;
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
    endtask : hw_reset
    task automatic t_reset;
        rd(LIS_ADDR_GLOBAL_STATUS);
        chk(rdv, 32'h0);
        rd(LIS_ADDR_INDICATOR_CONTROL);
        chk(rdv, 32'h4100);
        chk(32'(lit), 32'h0);
        rd(10'h3FC);
        chk({rdv[29:0], rsp}, {30'h0, LIS_RESP_SLVERR});
    endtask : t_reset
    task automatic t_summary;
        line_in.port_irq <= 1'b1;
        settle();
        rd(LIS_ADDR_GLOBAL_STATUS);
        chk(rdv, 32'h1);
        chk(32'({host_irq, irq}), 32'h2);
        wr(LIS_ADDR_GLOBAL_STATUS, rdv);
        chk(32'(rsp), 32'(LIS_RESP_OKAY));
        wr(LIS_ADDR_IRQ_MASK, 32'h1);
        chk(32'(irq), 32'h1);
        line_in.port_irq <= 1'b0;
        settle();
        rd(LIS_ADDR_GLOBAL_STATUS);
        chk(32'({rdv[0], host_irq, irq}), 32'h1);
        wr(LIS_ADDR_IRQ_STATUS, 32'h1);
        chk(32'(irq), 32'h0);
    endtask : t_summary
    task automatic t_force;
        wr(LIS_ADDR_INDICATOR_CONTROL, 32'h4900);
        chk(32'(host_irq), 32'h1);
        wr(LIS_ADDR_INDICATOR_CONTROL, 32'h4100);
        chk(32'(host_irq), 32'h0);
    endtask : t_force
    // Stretch zero keeps activity lamps in step with the inputs.
    task automatic t_modes;
        wr(LIS_ADDR_INDICATOR_CONTROL, 32'h0104);
        line_in.full_duplex <= 1'b1;
        settle();
        chk(32'(lit[0]), 32'h1);
        line_in.full_duplex <= 1'b0;
        wr(LIS_ADDR_INDICATOR_CONTROL, 32'h0180);
        line_in.fiber_link_up <= 1'b1;
        settle();
        chk(32'(lit[0]), 32'h1);
        line_in.fiber_link_up <= 1'b0;
        settle();
        chk(32'(lit[0]), 32'h0);
        wr(LIS_ADDR_INDICATOR_CONTROL, 32'h0118);
        line_in <= 8'hE2;
        settle();
        chk(32'(lit[3:1]), 32'h7);
        line_in <= 8'h60;
        settle();
        chk(32'(lit[3:1]), 32'h2);
        wr(LIS_ADDR_INDICATOR_CONTROL, 32'h0142);
        settle();
        chk(32'(lit[3:1]), 32'h7);
        line_in <= 8'h20;
        settle();
        chk(32'(lit[3:1]), 32'h3);
        wr(LIS_ADDR_INDICATOR_CONTROL, 32'h0101);
        settle();
        chk(32'(lit[3:1]), 32'h5);
        wr(LIS_ADDR_INDICATOR_CONTROL, 32'h8118);
        settle();
        chk(32'(lit), 32'h0);
        rd(LIS_ADDR_IRQ_STATUS);
        chk(rdv, 32'h2);
        chk(32'(irq), 32'h0);
        wr(LIS_ADDR_IRQ_STATUS, 32'h2);
        rd(LIS_ADDR_IRQ_STATUS);
        chk(rdv, 32'h0);
    endtask : t_modes
    task automatic t_soft;
        soft_reset <= 1'b1;
        repeat (2) @(posedge aclk);
        soft_reset <= 1'b0;
        rd(LIS_ADDR_INDICATOR_CONTROL);
        chk(rdv, 32'h8118);
        hw_reset();
        rd(LIS_ADDR_INDICATOR_CONTROL);
        chk(rdv, 32'h4100);
    endtask : t_soft
    // Main sequence.
    initial begin
        {soft_reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, line_in} = '0;
        s_axi_wstrb = 4'hF;
        aresetn = 1'b0;
        err_total = 0;
        samples_checked = 0;
        hw_reset();
        t_reset();
        t_summary();
        t_force();
        t_modes();
        t_soft();
        test_done();
    end
endmodule : test_led_and_interrupt_status
`default_nettype wire
